// ===== alu_dsp_map.vh
`ifndef ALU_DSP_MAP_VH
`define ALU_DSP_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Register offsets and reset values
`define ADDR_W          8
`define STATUS_OFFSET   8'h42
`define CONTROL_OFFSET  8'h44
`define STATUS_RESET    16'h0000
`define CONTROL_RESET   16'h0020
// Software may write only these control bits, and may clear bit 3 (set only by priority_raise)
`define CONTROL_WMASK   16'h30f3

////////////////////////////////////////////////////////////////////////////////
// Status register fields
`define ST_C            0
`define ST_Z            1
`define ST_OV           2
`define ST_N            3
`define ST_IPL_LO       5
`define ST_IPL_HI       7
`define ST_DC           8
`define ST_SAB          10
`define ST_OAB          11
`define ST_SB           12
`define ST_SA           13
`define ST_OB           14
`define ST_OA           15

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define CC_INT_MODE     0
`define CC_ROUND        1
`define CC_IPL_MSB      3
`define CC_SAT_WIDTH    4
`define CC_SAT_MEM      5
`define CC_SAT_B        6
`define CC_SAT_A        7
`define CC_SIGN_LO      12
`define CC_SIGN_HI      13
`define SIGN_SIGNED     2'h0
`define SIGN_UNSIGNED   2'h1

////////////////////////////////////////////////////////////////////////////////
// Operation codes
`define OP_ADD          5'h00
`define OP_SUB          5'h01
`define OP_AND          5'h02
`define OP_IOR          5'h03
`define OP_XOR          5'h04
`define OP_SL           5'h05
`define OP_LSR          5'h06
`define OP_ASR          5'h07
`define OP_MUL_SS       5'h08
`define OP_MUL_UU       5'h09
`define OP_MUL_SGN_UNS  5'h0a
`define OP_MUL_UNS_SGN  5'h0b
`define OP_MUL_LIT_S    5'h0c
`define OP_MUL_LIT_U    5'h0d
`define OP_MUL_BYTE     5'h0e
`define OP_DIV_S        5'h0f
`define OP_DIV_U        5'h10
`define OP_MPY          5'h11
`define OP_MAC          5'h12
`define OP_ADDAC        5'h13
`define OP_SUBAC        5'h14
`define OP_NEGAC        5'h15
`define OP_CLRAC        5'h16
`define OP_SAC          5'h17

////////////////////////////////////////////////////////////////////////////////
// Limits and counts
`define SAT32_POS       40'h007fffffff
`define SAT32_NEG       40'hff80000000
`define SAT40_POS       40'h7fffffffff
`define SAT40_NEG       40'h8000000000
`define MEM_SAT_POS     16'h7fff
`define MEM_SAT_NEG     16'h8000
`define ROUND_HALF      16'h8000
`define ROUND_LSB       41'h00000010000
`define DIV_CYCLES      16

`endif

// ===== div_iter.v
`timescale 1ns/1ps
`include "alu_dsp_map.vh"

module div_iter #(
	parameter STEPS = `DIV_CYCLES
)(
	input  wire        clk,
	input  wire        nrst,
	input  wire        start,
	input  wire        signed_mode,
	input  wire [31:0] dividend,
	input  wire [15:0] divisor,
	output reg         done,
	output reg  [15:0] quotient,
	output reg  [15:0] remainder
);

reg        active;
reg  [4:0] cnt;
reg  [15:0] rem;
reg  [15:0] lo;
reg  [15:0] dvs;
reg        neg_q;
reg        neg_r;

wire [31:0] mag_dd = (signed_mode && dividend[31]) ? (32'h0 - dividend) : dividend;
wire [15:0] mag_ds = (signed_mode && divisor[15]) ? (16'h0 - divisor) : divisor;
// First step runs on the start edge so results land after STEPS busy cycles
wire [15:0] s_rem  = active ? rem : mag_dd[31:16];
wire [15:0] s_lo   = active ? lo : mag_dd[15:0];
wire [15:0] s_dvs  = active ? dvs : mag_ds;
wire [16:0] trial  = {s_rem, s_lo[15]};
wire [17:0] diff   = {1'b0, trial} - {2'b00, s_dvs};
wire        fits   = ~diff[17];
wire [15:0] q_fin  = {s_lo[14:0], fits};
wire [15:0] r_fin  = fits ? diff[15:0] : trial[15:0];

////////////////////////////////////////////////////////////////////////////////
// One restoring step per divisor bit, whatever the dividend length
always @(posedge clk)
begin
	if (!nrst)
	begin
		active    <= 1'b0;
		cnt       <= 5'h00;
		rem       <= 16'h0000;
		lo        <= 16'h0000;
		dvs       <= 16'h0000;
		neg_q     <= 1'b0;
		neg_r     <= 1'b0;
		done      <= 1'b0;
		quotient  <= 16'h0000;
		remainder <= 16'h0000;
	end
	else
	begin
		done <= 1'b0;
		if (start && !active)
		begin
			active <= 1'b1;
			cnt    <= 5'h01;
			rem    <= r_fin;
			lo     <= q_fin;
			dvs    <= mag_ds;
			neg_q  <= signed_mode & (dividend[31] ^ divisor[15]);
			neg_r  <= signed_mode & dividend[31];
		end
		else if (active)
		begin
			rem <= r_fin;
			lo  <= q_fin;
			cnt <= cnt + 5'h01;
			if (cnt == STEPS[4:0] - 5'h01)
			begin
				active    <= 1'b0;
				done      <= 1'b1;
				quotient  <= neg_q ? (16'h0 - q_fin) : q_fin;
				remainder <= neg_r ? (16'h0 - r_fin) : r_fin;
			end
		end
	end
end

endmodule // div_iter

// ===== cpu_alu_dsp_engine.v
`timescale 1ns/1ps
`include "alu_dsp_map.vh"

module cpu_alu_dsp_engine #(
	parameter DIV_STEPS = `DIV_CYCLES
)(
	input  wire                clk,
	input  wire                nrst,
	input  wire [`ADDR_W-1:0]  addr,
	input  wire [15:0]         wdata,
	input  wire                wr,
	input  wire                rd,
	output reg  [15:0]         rdata,
	input  wire                op_valid,
	input  wire [4:0]          op_code,
	input  wire                op_byte,
	input  wire [3:0]          op_wa,
	input  wire [3:0]          op_wb,
	input  wire [3:0]          op_wd,
	input  wire [4:0]          op_lit,
	input  wire                op_src_mem,
	input  wire                op_dst_mem,
	input  wire                op_acc_b,
	input  wire [15:0]         mem_rdata,
	output reg  [15:0]         mem_wdata,
	output reg                 mem_we,
	input  wire                priority_raise,
	output wire [3:0]          priority_level,
	output wire                busy,
	input  wire [3:0]          w_sel,
	output reg  [15:0]         w_value,
	output reg  [39:0]         accumulator_a,
	output reg  [39:0]         accumulator_b
);

reg  [15:0]  status;
reg  [15:0]  core_control;
reg          div_busy;
wire [255:0] w_flat;
wire         div_done;
wire [15:0]  div_q;
wire [15:0]  div_r;

wire go = op_valid & ~div_busy;
assign busy = div_busy;
assign priority_level = {core_control[`CC_IPL_MSB], status[`ST_IPL_HI:`ST_IPL_LO]};

////////////////////////////////////////////////////////////////////////////////
// Operand fetch
wire [15:0] a      = w_flat[{op_wa, 4'h0} +: 16];
wire [15:0] b      = op_src_mem ? mem_rdata : w_flat[{op_wb, 4'h0} +: 16];
wire [15:0] w_dest = w_flat[{op_wd, 4'h0} +: 16];
wire [15:0] a_pair = w_flat[{op_wa[3:1], 1'b1, 4'h0} +: 16];
wire [15:0] a_even = w_flat[{op_wa[3:1], 1'b0, 4'h0} +: 16];

////////////////////////////////////////////////////////////////////////////////
// ALU; byte operands sit in the top byte so C, OV and N share taps across widths; Z, DC and right-shift carry pick by width
wire        is_sub = (op_code == `OP_SUB);
wire [15:0] ax     = op_byte ? {a[7:0], 8'h00} : a;
wire [15:0] bx     = op_byte ? {b[7:0], 8'h00} : b;
wire [15:0] by     = is_sub ? ~bx : bx;
wire [16:0] cin    = is_sub ? (op_byte ? 17'h00100 : 17'h00001) : 17'h00000;
wire [16:0] sum17  = {1'b0, ax} + {1'b0, by} + cin;
wire [3:0]  dc_bit = op_byte ? 4'hc : 4'h8;
wire        dc_out = ax[dc_bit] ^ by[dc_bit] ^ sum17[dc_bit];

reg  [15:0] r;
reg         f_c;
reg         upd_c;
reg         upd_arith;
reg         alu_op;

always @*
begin
	r         = 16'h0000;
	f_c       = 1'b0;
	upd_c     = 1'b0;
	upd_arith = 1'b0;
	alu_op    = 1'b1;
	case (op_code)
		`OP_ADD, `OP_SUB:
		begin
			r         = sum17[15:0];
			f_c       = sum17[16];
			upd_c     = 1'b1;
			upd_arith = 1'b1;
		end
		`OP_AND: r = ax & bx;
		`OP_IOR: r = ax | bx;
		`OP_XOR: r = ax ^ bx;
		`OP_SL:
		begin
			r     = {ax[14:0], 1'b0};
			f_c   = ax[15];
			upd_c = 1'b1;
		end
		`OP_LSR:
		begin
			r     = {1'b0, ax[15:1]};
			f_c   = op_byte ? ax[8] : ax[0];
			upd_c = 1'b1;
		end
		`OP_ASR:
		begin
			r     = {ax[15], ax[15:1]};
			f_c   = op_byte ? ax[8] : ax[0];
			upd_c = 1'b1;
		end
		default: alu_op = 1'b0;
	endcase
end

wire        f_z     = op_byte ? (r[15:8] == 8'h00) : (r == 16'h0000);
wire        f_ov    = (ax[15] == by[15]) && (sum17[15] != ax[15]);
wire [7:0]  dest_hi = op_dst_mem ? mem_rdata[15:8] : w_dest[15:8];
wire [15:0] alu_out = op_byte ? {dest_hi, r[15:8]} : r;

////////////////////////////////////////////////////////////////////////////////
// Shared 17x17 multiplier
wire [1:0] sign_sel = core_control[`CC_SIGN_HI:`CC_SIGN_LO];
reg  [16:0] ma;
reg  [16:0] mb;

always @*
begin
	ma = {a[15], a};
	mb = {b[15], b};
	case (op_code)
		`OP_MUL_UU:      begin ma = {1'b0, a}; mb = {1'b0, b}; end
		`OP_MUL_SGN_UNS: mb = {1'b0, b};
		`OP_MUL_UNS_SGN: ma = {1'b0, a};
		`OP_MUL_LIT_S:   mb = {12'h000, op_lit};
		`OP_MUL_LIT_U:   begin ma = {1'b0, a}; mb = {12'h000, op_lit}; end
		`OP_MUL_BYTE:    begin ma = {9'h000, a[7:0]}; mb = {9'h000, b[7:0]}; end
		`OP_MPY, `OP_MAC:
		begin
			if (sign_sel == `SIGN_UNSIGNED)
			begin
				ma = {1'b0, a};
				mb = {1'b0, b};
			end
			else if (sign_sel != `SIGN_SIGNED)
				ma = {1'b0, a};
		end
		default: ma = {a[15], a};
	endcase
end

wire signed [33:0] prod = $signed(ma) * $signed(mb);
wire        is_mul  = (op_code >= `OP_MUL_SS) && (op_code <= `OP_MUL_BYTE);
wire [39:0] prod40  = core_control[`CC_INT_MODE] ? {{6{prod[33]}}, prod}
                                                : {{5{prod[33]}}, prod, 1'b0};

////////////////////////////////////////////////////////////////////////////////
// 40-bit adder with saturation
wire [39:0] tgt = op_acc_b ? accumulator_b : accumulator_a;
wire [39:0] oth = op_acc_b ? accumulator_a : accumulator_b;
reg  [39:0] xs;
reg  [39:0] ys;
reg         dsub;
reg         acc_op;

always @*
begin
	xs     = 40'h0;
	ys     = 40'h0;
	dsub   = 1'b0;
	acc_op = 1'b1;
	case (op_code)
		`OP_MPY:   ys = prod40;
		`OP_MAC:   begin xs = tgt; ys = prod40; end
		`OP_ADDAC: begin xs = tgt; ys = oth; end
		`OP_SUBAC: begin xs = tgt; ys = oth; dsub = 1'b1; end
		`OP_NEGAC: begin ys = tgt; dsub = 1'b1; end
		`OP_CLRAC: ys = 40'h0;
		default:   acc_op = 1'b0;
	endcase
end

wire [40:0] ye41  = dsub ? (41'h0 - {ys[39], ys}) : {ys[39], ys};
wire [40:0] sum41 = {xs[39], xs} + ye41;
wire        ov40  = sum41[40] ^ sum41[39];
wire        ov32  = ~(&sum41[40:31]) & (|sum41[40:31]);
wire        sat_en = op_acc_b ? core_control[`CC_SAT_B] : core_control[`CC_SAT_A];
wire        wide  = core_control[`CC_SAT_WIDTH];
reg  [39:0] acc_new;
reg         sat_hit;

always @*
begin
	acc_new = sum41[39:0];
	sat_hit = 1'b0;
	if (sat_en && !wide && ov32)
	begin
		acc_new = sum41[40] ? `SAT32_NEG : `SAT32_POS;
		sat_hit = 1'b1;
	end
	else if (sat_en && wide && ov40)
	begin
		acc_new = sum41[40] ? `SAT40_NEG : `SAT40_POS;
		sat_hit = 1'b1;
	end
end

// Overflow into guard bits only; a 40-bit wrap is clamped whenever saturation is on, to 32 bits unless CC_SAT_WIDTH is set
wire acc_guard = ~(&acc_new[39:31]) & (|acc_new[39:31]);

////////////////////////////////////////////////////////////////////////////////
// Store path: round the upper word, then clamp it for memory
wire [15:0] low16 = tgt[15:0];
wire        round_up = core_control[`CC_ROUND] ? low16[15]
                     : ((low16 > `ROUND_HALF) || ((low16 == `ROUND_HALF) && tgt[16]));
wire [40:0] rounded = {tgt[39], tgt} + (round_up ? `ROUND_LSB : 41'h0);
wire        st_ovf  = ~(&rounded[40:31]) & (|rounded[40:31]);
wire [15:0] sac_out = (core_control[`CC_SAT_MEM] && st_ovf)
                    ? (rounded[40] ? `MEM_SAT_NEG : `MEM_SAT_POS) : rounded[31:16];

////////////////////////////////////////////////////////////////////////////////
// Divider
wire        is_div   = (op_code == `OP_DIV_S) || (op_code == `OP_DIV_U);
wire        div_sgn  = (op_code == `OP_DIV_S);
wire [31:0] dividend = op_byte ? {a_pair, a_even}
                     : (div_sgn ? {{16{a[15]}}, a} : {16'h0000, a});
wire        div_go   = go & is_div;

div_iter #(
	.STEPS       (DIV_STEPS)
) u_div (
	.clk         (clk),
	.nrst        (nrst),
	.start       (div_go),
	.signed_mode (div_sgn),
	.dividend    (dividend),
	.divisor     (w_flat[{op_wb, 4'h0} +: 16]),
	.done        (div_done),
	.quotient    (div_q),
	.remainder   (div_r)
);

always @(posedge clk)
begin
	if (!nrst)
		div_busy <= 1'b0;
	else if (div_go)
		div_busy <= 1'b1;
	else if (div_done)
		div_busy <= 1'b0;
end

////////////////////////////////////////////////////////////////////////////////
// Working register write ports
wire        is_sac = (op_code == `OP_SAC);
reg         en0;
reg         en1;
reg  [3:0]  idx0;
reg  [3:0]  idx1;
reg  [15:0] d0;
reg  [15:0] d1;

always @*
begin
	en0  = 1'b0;
	en1  = 1'b0;
	idx0 = op_wd;
	idx1 = {op_wd[3:1], 1'b1};
	d0   = alu_out;
	d1   = prod[31:16];
	if (div_done)
	begin
		en0  = 1'b1;
		en1  = 1'b1;
		idx0 = 4'h0;
		idx1 = 4'h1;
		d0   = div_q;
		d1   = div_r;
	end
	else if (go && is_mul)
	begin
		en0  = 1'b1;
		en1  = 1'b1;
		idx0 = {op_wd[3:1], 1'b0};
		d0   = prod[15:0];
	end
	else if (go && (alu_op || is_sac) && !op_dst_mem)
	begin
		en0 = 1'b1;
		d0  = is_sac ? sac_out : alu_out;
	end
end

genvar k;
generate
	for (k = 0; k < 16; k = k + 1)
	begin : g_w
		reg [15:0] w;
		always @(posedge clk)
		begin
			if (!nrst)
				w <= 16'h0000;
			else if (en0 && idx0 == k)
				w <= d0;
			else if (en1 && idx1 == k)
				w <= d1;
		end
		assign w_flat[k*16 +: 16] = w;
	end
endgenerate

always @(posedge clk)
begin
	if (!nrst)
	begin
		mem_we    <= 1'b0;
		mem_wdata <= 16'h0000;
		w_value   <= 16'h0000;
	end
	else
	begin
		w_value <= w_flat[{w_sel, 4'h0} +: 16];
		mem_we  <= go && op_dst_mem && (alu_op || is_sac);
		if (go && op_dst_mem && (alu_op || is_sac))
			mem_wdata <= is_sac ? sac_out : alu_out;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Accumulators
always @(posedge clk)
begin
	if (!nrst)
	begin
		accumulator_a <= 40'h0;
		accumulator_b <= 40'h0;
	end
	else if (go && acc_op)
	begin
		if (op_acc_b)
			accumulator_b <= acc_new;
		else
			accumulator_a <= acc_new;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Status and control registers; hardware updates beat a same-cycle write
reg [15:0] next_status;
reg [15:0] next_control;

always @*
begin
	next_status = (wr && addr == `STATUS_OFFSET) ? wdata : status;
	if (go && alu_op)
	begin
		next_status[`ST_Z] = f_z;
		next_status[`ST_N] = r[15];
		if (upd_c)
			next_status[`ST_C] = f_c;
		if (upd_arith)
		begin
			next_status[`ST_OV] = f_ov;
			next_status[`ST_DC] = dc_out;
		end
		else
			next_status[`ST_OV] = 1'b0;
	end
	if (go && acc_op)
	begin
		if (op_acc_b)
		begin
			next_status[`ST_OB] = acc_guard;
			next_status[`ST_SB] = next_status[`ST_SB] | sat_hit;
		end
		else
		begin
			next_status[`ST_OA] = acc_guard;
			next_status[`ST_SA] = next_status[`ST_SA] | sat_hit;
		end
	end
	next_status[`ST_OAB] = next_status[`ST_OA] | next_status[`ST_OB];
	next_status[`ST_SAB] = next_status[`ST_SA] | next_status[`ST_SB];
	next_status[9]       = 1'b0;
	next_status[4]       = 1'b0;

	next_control = core_control;
	if (wr && addr == `CONTROL_OFFSET)
	begin
		next_control = (wdata & `CONTROL_WMASK) | (core_control & ~`CONTROL_WMASK);
		next_control[`CC_IPL_MSB] = core_control[`CC_IPL_MSB] & wdata[`CC_IPL_MSB];
	end
	if (priority_raise)
		next_control[`CC_IPL_MSB] = 1'b1;
end

always @(posedge clk)
begin
	if (!nrst)
	begin
		status       <= `STATUS_RESET;
		core_control <= `CONTROL_RESET;
		rdata        <= 16'h0000;
	end
	else
	begin
		status       <= next_status;
		core_control <= next_control;
		if (rd && addr == `STATUS_OFFSET)
			rdata <= status;
		else if (rd && addr == `CONTROL_OFFSET)
			rdata <= core_control;
		else
			rdata <= 16'h0000;
	end
end

endmodule // cpu_alu_dsp_engine

// ===== alu_dsp_monitor.sv
`timescale 1ns/1ps
`include "alu_dsp_map.vh"

module alu_dsp_monitor #(
	parameter DIV_STEPS = 16
)(
	input wire        clk,
	input wire        nrst,
	input wire [7:0]  addr,
	input wire        rd,
	input wire [15:0] rdata,
	input wire        op_valid,
	input wire [4:0]  op_code,
	input wire        op_dst_mem,
	input wire        mem_we,
	input wire        priority_raise,
	input wire [3:0]  priority_level,
	input wire        busy
);
	////////////////////////////////////////////////////////////////////////////
	// Counts busy cycles; a counter keeps the divide length check cheap to unroll
	logic [7:0] busy_cnt;
	wire        take = op_valid && !busy;
	wire        rd_st = rd && addr == `STATUS_OFFSET;
	wire        rd_cc = rd && addr == `CONTROL_OFFSET;

	always_ff @(posedge clk)
		if (!nrst)
			busy_cnt <= 8'h00;
		else
			busy_cnt <= busy ? busy_cnt + 8'h01 : 8'h00;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	////////////////////////////////////////////////////////////////////////////
	property p_ctrl_bits; rd_cc |=> (rdata & ~16'h30fb) == 16'h0000; endproperty
	a_ctrl_bits: assert property (p_ctrl_bits) else $error("control reads an unimplemented bit");
	property p_ctrl_ipl; rd_cc |=> rdata[3] == $past(priority_level[3]); endproperty
	a_ctrl_ipl: assert property (p_ctrl_ipl) else $error("priority msb differs from control");
	property p_status_ipl; rd_st |=> rdata[7:5] == $past(priority_level[2:0]); endproperty
	a_status_ipl: assert property (p_status_ipl) else $error("priority low bits differ from status");
	property p_status_free; rd_st |=> !rdata[9] && !rdata[4]; endproperty
	a_status_free: assert property (p_status_free) else $error("status reads an absent flag");
	property p_raise; priority_raise |=> priority_level[3]; endproperty
	a_raise: assert property (p_raise) else $error("priority raise not seen");
	property p_sac_mem; take && op_code == `OP_SAC && op_dst_mem |=> mem_we; endproperty
	a_sac_mem: assert property (p_sac_mem) else $error("store to memory gave no write");
	property p_mem_cause; mem_we |-> $past(take && op_dst_mem); endproperty
	a_mem_cause: assert property (p_mem_cause) else $error("memory write without a request");
	property p_div_start; take && (op_code == `OP_DIV_S || op_code == `OP_DIV_U) |=> busy; endproperty
	a_div_start: assert property (p_div_start) else $error("divide did not start");
	property p_div_len; $fell(busy) |-> busy_cnt == DIV_STEPS; endproperty
	a_div_len: assert property (p_div_len) else $error("divide length wrong");
	property p_div_bound; busy |-> busy_cnt < DIV_STEPS; endproperty
	a_div_bound: assert property (p_div_bound) else $error("divide runs too long");

	c_div: cover property (take && op_code == `OP_DIV_S);
	c_raise: cover property (priority_raise);
	c_mem: cover property (mem_we);
endmodule // alu_dsp_monitor

bind cpu_alu_dsp_engine alu_dsp_monitor #(.DIV_STEPS(DIV_STEPS)) mon (.clk(clk), .nrst(nrst), .addr(addr),
	.rd(rd), .rdata(rdata), .op_valid(op_valid), .op_code(op_code), .op_dst_mem(op_dst_mem), .mem_we(mem_we),
	.priority_raise(priority_raise), .priority_level(priority_level), .busy(busy));

// ===== tb_top.sv
`timescale 1ns/1ps
`include "alu_dsp_map.vh"

module tb_top;
	localparam DIV_STEPS = 16;
	logic        clk = 0, nrst = 0, wr = 0, rd = 0, op_valid = 0, op_byte = 0;
	logic        op_src_mem = 0, op_dst_mem = 0, op_acc_b = 0, priority_raise = 0;
	logic [7:0]  addr = 0;
	logic [15:0] wdata = 0, mem_rdata = 0;
	logic [4:0]  op_code = 0, op_lit = 5'h1f;
	logic [3:0]  op_wa = 0, op_wb = 0, op_wd = 0, w_sel = 0;
	logic [15:0] rdata, mem_wdata, w_value;
	logic        mem_we, busy;
	logic [3:0]  priority_level;
	logic [39:0] accumulator_a, accumulator_b;
	int          fail_count = 0;
	int          checks_done = 0;
	int          n;

	cpu_alu_dsp_engine #(.DIV_STEPS(DIV_STEPS)) dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .op_valid(op_valid), .op_code(op_code), .op_byte(op_byte),
		.op_wa(op_wa), .op_wb(op_wb), .op_wd(op_wd), .op_lit(op_lit), .op_src_mem(op_src_mem),
		.op_dst_mem(op_dst_mem), .op_acc_b(op_acc_b), .mem_rdata(mem_rdata), .mem_wdata(mem_wdata),
		.mem_we(mem_we), .priority_raise(priority_raise), .priority_level(priority_level), .busy(busy),
		.w_sel(w_sel), .w_value(w_value), .accumulator_a(accumulator_a), .accumulator_b(accumulator_b));

	initial
	begin
		forever #12.5 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up;
		if (fail_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input string what, input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
		#1;
	endtask

	// Read data stand only in the cycle after the strobe, so sample there
	task automatic rd_reg(input logic [7:0] a, input logic [15:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check("rdata", rdata, exp);
	endtask

	// Flags are {acc_b, dst_mem, src_mem, byte}
	task automatic op(input logic [4:0] c, input logic [3:0] a, b, d, input logic [15:0] m, input logic [3:0] f);
		@(posedge clk);
		op_code <= c;
		op_wa <= a;
		op_wb <= b;
		op_wd <= d;
		mem_rdata <= m;
		{op_acc_b, op_dst_mem, op_src_mem, op_byte} <= f;
		op_valid <= 1'b1;
		@(posedge clk);
		op_valid <= 1'b0;
		#1;
	endtask

	task automatic peek(input logic [3:0] s, input logic [15:0] exp);
		@(posedge clk);
		w_sel <= s;
		@(posedge clk);
		#1;
		check("w_value", w_value, exp);
	endtask

	// Registers are filled by adding memory data to the zero in register 0
	task automatic load(input logic [3:0] d, input logic [15:0] v);
		op(`OP_ADD, 4'h0, 4'h0, d, v, 4'h2);
	endtask

	task automatic alu_chk(input logic [4:0] c, input logic [15:0] exp);
		op(c, 4'h8, 4'h9, 4'h5, 16'h0000, 4'h0);
		peek(4'h5, exp);
	endtask

	task automatic mul_chk(input logic [4:0] c, input logic [31:0] exp);
		op(c, 4'h8, 4'h9, 4'h6, 16'h0000, 4'h0);
		peek(4'h6, exp[15:0]);
		peek(4'h7, exp[31:16]);
	endtask

	task automatic dsp_mpy(input logic [15:0] cc, input logic [3:0] a, b, input logic ab, input logic [39:0] exp);
		wr_reg(`CONTROL_OFFSET, cc);
		op(`OP_MPY, a, b, 4'h0, 16'h0000, {ab, 3'h0});
		check("accumulator", ab ? accumulator_b : accumulator_a, exp);
	endtask

	task automatic acc_op(input logic [4:0] c, input logic [39:0] exp);
		op(c, 4'h0, 4'h0, 4'h0, 16'h0000, 4'h0);
		check("accumulator_a", accumulator_a, exp);
	endtask

	task automatic sac_chk(input logic [15:0] cc, input logic [3:0] a, b, input logic [15:0] exp);
		wr_reg(`CONTROL_OFFSET, cc);
		op(`OP_MPY, a, b, 4'h0, 16'h0000, 4'h0);
		op(`OP_SAC, 4'h0, 4'h0, 4'h0, 16'h0000, 4'h4);
		check("mem_we", mem_we, 1'b1);
		check("mem_wdata", mem_wdata, exp);
	endtask

	// A poke during busy must be ignored; it uses two of the busy cycles
	task automatic div_run(input logic [4:0] c, input logic lng, poke, input logic [15:0] q, r);
		op(c, 4'ha, 4'hc, 4'h0, 16'h0000, {3'h0, lng});
		if (poke)
			load(4'hf, 16'h1234);
		n = 0;
		while (busy === 1'b1 && n < 100)
		begin
			@(posedge clk);
			#1;
			n++;
		end
		check("busy cycles", n, poke ? DIV_STEPS - 2 : DIV_STEPS);
		peek(4'h0, q);
		peek(4'h1, r);
	endtask

	////////////////////////////////////////////////////////////////////////////
	initial
	begin
		#(25 * 5000);
		fail_count++;
		wrap_up();
	end

	initial
	begin
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		rd_reg(`STATUS_OFFSET, `STATUS_RESET);
		rd_reg(`CONTROL_OFFSET, `CONTROL_RESET);
		rd_reg(8'h46, 16'h0000);
		wr_reg(`CONTROL_OFFSET, 16'hffff);
		rd_reg(`CONTROL_OFFSET, 16'h30f3);
		load(4'h1, 16'h7fff);
		load(4'h2, 16'h0001);
		op(`OP_ADD, 4'h1, 4'h2, 4'h3, 16'h0000, 4'h0);
		rd_reg(`STATUS_OFFSET, 16'h010c);
		peek(4'h3, 16'h8000);
		op(`OP_SUB, 4'h1, 4'h2, 4'h4, 16'h0000, 4'h0);
		rd_reg(`STATUS_OFFSET, 16'h0101);
		peek(4'h4, 16'h7ffe);
		op(`OP_ADD, 4'h1, 4'h2, 4'h1, 16'h0000, 4'h1);
		rd_reg(`STATUS_OFFSET, 16'h0103);
		peek(4'h1, 16'h7f00);
		op(`OP_ADD, 4'h2, 4'h0, 4'h0, 16'h0010, 4'h6);
		check("mem_wdata", mem_wdata, 16'h0011);
		load(4'h8, 16'hfffe);
		load(4'h9, 16'hffff);
		alu_chk(`OP_AND, 16'hfffe);
		alu_chk(`OP_IOR, 16'hffff);
		alu_chk(`OP_XOR, 16'h0001);
		alu_chk(`OP_SL, 16'hfffc);
		alu_chk(`OP_LSR, 16'h7fff);
		alu_chk(`OP_ASR, 16'hffff);
		mul_chk(`OP_MUL_SS, 32'h00000002);
		mul_chk(`OP_MUL_UU, 32'hfffd0002);
		mul_chk(`OP_MUL_SGN_UNS, 32'hfffe0002);
		mul_chk(`OP_MUL_UNS_SGN, 32'hffff0002);
		mul_chk(`OP_MUL_LIT_S, 32'hffffffc2);
		mul_chk(`OP_MUL_LIT_U, 32'h001effc2);
		mul_chk(`OP_MUL_BYTE, 32'h0000fd02);
		dsp_mpy(16'h0000, 4'h2, 4'h2, 1'b0, 40'h0000000002);
		dsp_mpy(16'h0001, 4'h9, 4'h9, 1'b0, 40'h0000000001);
		dsp_mpy(16'h1001, 4'h9, 4'h9, 1'b0, 40'h00fffe0001);
		dsp_mpy(16'h2001, 4'h9, 4'h9, 1'b0, 40'hffffff0001);
		dsp_mpy(16'h1081, 4'h9, 4'h9, 1'b0, 40'h007fffffff);
		dsp_mpy(16'h1091, 4'h9, 4'h9, 1'b0, 40'h00fffe0001);
		dsp_mpy(16'h1041, 4'h9, 4'h9, 1'b1, 40'h007fffffff);
		dsp_mpy(16'h1081, 4'h9, 4'h9, 1'b1, 40'h00fffe0001);
		dsp_mpy(16'h0001, 4'h8, 4'h2, 1'b0, 40'hfffffffffe);
		dsp_mpy(16'h0001, 4'h2, 4'h2, 1'b1, 40'h0000000001);
		acc_op(`OP_ADDAC, 40'hffffffffff);
		acc_op(`OP_SUBAC, 40'hfffffffffe);
		acc_op(`OP_NEGAC, 40'h0000000002);
		op(`OP_MAC, 4'h2, 4'h2, 4'h0, 16'h0000, 4'h0);
		check("accumulator_a", accumulator_a, 40'h0000000003);
		load(4'hd, 16'h8000);
		load(4'he, 16'h0003);
		sac_chk(16'h1001, 4'hd, 4'h2, 16'h0000);
		sac_chk(16'h1003, 4'hd, 4'h2, 16'h0001);
		sac_chk(16'h1001, 4'hd, 4'he, 16'h0002);
		sac_chk(16'h1021, 4'h9, 4'h9, 16'h7fff);
		acc_op(`OP_CLRAC, 40'h0000000000);
		load(4'ha, 16'hfff9);
		load(4'hb, 16'hffff);
		load(4'hc, 16'h0002);
		div_run(`OP_DIV_S, 1'b1, 1'b0, 16'hfffd, 16'hffff);
		div_run(`OP_DIV_U, 1'b0, 1'b1, 16'h7ffc, 16'h0001);
		peek(4'hf, 16'h0000);
		wr_reg(`STATUS_OFFSET, 16'h00e0);
		check("priority_level", priority_level, 4'h7);
		@(posedge clk);
		priority_raise <= 1'b1;
		@(posedge clk);
		priority_raise <= 1'b0;
		#1;
		check("priority_level", priority_level, 4'hf);
		wr_reg(`CONTROL_OFFSET, 16'h0000);
		check("priority_level", priority_level, 4'h7);
		wrap_up();
	end
endmodule // tb_top
